//--- hdl/dvc_pkg.sv
// Purpose: constants for the stepping, drain and supply detector config bank
// Assumes: byte-wide registers on a 32-bit Avalon-MM word bus
// Notes:   printed offsets are register indices; byte address is index * 4
package dvc_pkg;

  // ==========================================================================
  // register indices and byte addresses
  localparam int unsigned DVC_ADDR_W         = 10;
  localparam logic [7:0]  DVC_IDX_STEP       = 8'hD2;
  localparam logic [7:0]  DVC_IDX_GUARD      = 8'hD3;
  localparam logic [7:0]  DVC_IDX_RISE       = 8'hD4;
  localparam logic [7:0]  DVC_IDX_STAGE      = 8'hD0;
  localparam logic [DVC_ADDR_W-1:0] DVC_ADDR_STEP  = {DVC_IDX_STEP, 2'b00};
  localparam logic [DVC_ADDR_W-1:0] DVC_ADDR_GUARD = {DVC_IDX_GUARD, 2'b00};
  localparam logic [DVC_ADDR_W-1:0] DVC_ADDR_RISE  = {DVC_IDX_RISE, 2'b00};
  localparam logic [DVC_ADDR_W-1:0] DVC_ADDR_STAGE = {DVC_IDX_STAGE, 2'b00};

  // ==========================================================================
  // reset values
  localparam logic [7:0]  DVC_RST_STEP       = 8'h40;
  localparam logic [7:0]  DVC_RST_GUARD      = 8'h20;
  localparam logic [7:0]  DVC_RST_RISE       = 8'h03;
  localparam logic [7:0]  DVC_RST_STAGE      = 8'h00;

  // ==========================================================================
  // writable bit masks; zero bits are unimplemented
  localparam logic [7:0]  DVC_MASK_STEP      = 8'h7F;
  localparam logic [7:0]  DVC_MASK_GUARD     = 8'hFF;
  localparam logic [7:0]  DVC_MASK_RISE      = 8'h1F;
  localparam logic [7:0]  DVC_MASK_STAGE     = 8'h01;

  // ==========================================================================
  // field positions
  localparam int unsigned DVC_BIT_DOWN_RAMP  = 6;
  localparam int unsigned DVC_SLEW_HI        = 5;
  localparam int unsigned DVC_SLEW_LO        = 4;
  localparam int unsigned DVC_DRAIN_HI       = 3;
  localparam int unsigned DVC_DRAIN_LO       = 2;
  localparam int unsigned DVC_BIT_DRAIN_EN   = 1;
  localparam int unsigned DVC_BIT_DRAIN_STOP = 0;
  localparam int unsigned DVC_BIT_GUARD_EN   = 7;
  localparam int unsigned DVC_BIT_REG_SEL    = 6;
  localparam int unsigned DVC_BIT_DET_EN     = 5;
  localparam int unsigned DVC_LEVEL_HI       = 4;
  localparam int unsigned DVC_LEVEL_LO       = 0;
  localparam int unsigned DVC_BIT_STAGE_EN   = 0;

  // ==========================================================================
  // encodings
  localparam logic [1:0]  DVC_SLEW_40MV      = 2'h0;
  localparam logic [1:0]  DVC_SLEW_20MV      = 2'h1;
  localparam logic [1:0]  DVC_SLEW_1MV       = 2'h2;
  localparam logic [1:0]  DVC_SLEW_HALF_MV   = 2'h3;
  localparam logic [1:0]  DVC_DRAIN_25MA     = 2'h0;
  localparam logic [1:0]  DVC_DRAIN_50MA     = 2'h1;
  localparam logic [1:0]  DVC_DRAIN_75MA     = 2'h2;
  // detector levels in millivolts: base plus 200 mV per code
  localparam logic [13:0] DVC_FALL_BASE_MV   = 14'h0A8C;
  localparam logic [13:0] DVC_RISE_BASE_MV   = 14'h0AF0;
  localparam logic [13:0] DVC_LEVEL_STEP_MV  = 14'h00C8;

  typedef enum logic [1:0] {
    DVC_IDLE,
    DVC_ANSWER
  } dvc_state_t;

endpackage : dvc_pkg

//--- hdl/dvc_config_regs.sv
// Purpose: config bank for voltage stepping, output drain, input guard and
//          supply detector thresholds, on an Avalon-MM slave
// Assumes: sys_clk_i at 125 MHz, inputs synchronous to it
// Notes:   every access answers after one wait cycle
//
// Contract
// - unimplemented bits ignore writes, read zero
// - bit 6 active down ramp enable, reset 1
// - bits 5:4 slew select for both directions
// - bits 3:2 drain current, codes 2,3 equal
// - bit 1 ties drain to stage enable
// - bit 0 drains until stop threshold
// - guard bit 7 enables input overvolt guard
// - guard bit 6 selects regulation over guard
// - guard bit 5 enables supply detector, reset 1
// - fall level 2.7V plus 0.2V per code
// - rise register resets 0x03, 2.8V base
// - stepping register resets to 0x40
// - stage enable is bit 0 of D0
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module dvc_config_regs (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [dvc_pkg::DVC_ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  output logic      [1:0]                    avs_response_o,
  output logic                               active_down_ramp_enable_o,
  output logic      [1:0]                    voltage_step_slew_select_o,
  output logic      [1:0]                    drain_current_select_o,
  output logic                               drain_with_stage_enable_o,
  output logic                               drain_to_stop_level_o,
  output logic                               power_stage_enable_o,
  output logic                               drain_on_stage_off_o,
  output logic                               input_overvolt_guard_enable_o,
  output logic                               input_regulation_select_o,
  output logic                               supply_detector_enable_o,
  output logic      [4:0]                    supply_detector_fall_level_o,
  output logic      [4:0]                    supply_detector_rise_level_o,
  output logic      [13:0]                   fall_level_mv_o,
  output logic      [13:0]                   rise_level_mv_o
);
  import dvc_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_byte = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_byte

  function automatic logic [13:0] level_mv(input logic [13:0] base,
                                           input logic [4:0]  code);
    level_mv = base + 14'(DVC_LEVEL_STEP_MV * 14'(code));
  endfunction : level_mv

  // ==========================================================================
  // state
  dvc_state_t  state;
  logic [7:0]  step_cfg;
  logic [7:0]  guard_cfg;
  logic [7:0]  rise_cfg;
  logic [7:0]  stage_cfg;

  // ==========================================================================
  // decode
  wire         req         = avs_read_i | avs_write_i;
  wire         sel_step    = (avs_address_i == DVC_ADDR_STEP);
  wire         sel_guard   = (avs_address_i == DVC_ADDR_GUARD);
  wire         sel_rise    = (avs_address_i == DVC_ADDR_RISE);
  wire         sel_stage   = (avs_address_i == DVC_ADDR_STAGE);
  wire         hit         = sel_step | sel_guard | sel_rise | sel_stage;
  wire         take        = (state == DVC_ANSWER);
  wire         wr_ok       = take & avs_write_i & avs_byteenable_i[0];
  wire [7:0]   wbyte       = avs_writedata_i[7:0];
  wire [7:0]   rd_byte     = sel_step  ? step_cfg  :
                             sel_guard ? guard_cfg :
                             sel_rise  ? rise_cfg  :
                             sel_stage ? stage_cfg : 8'h00;
  wire [7:0]   next_step   = (wr_ok & sel_step)
                             ? merge_byte(8'h00, wbyte, DVC_MASK_STEP)
                             : step_cfg;
  wire [7:0]   next_guard  = (wr_ok & sel_guard)
                             ? merge_byte(8'h00, wbyte, DVC_MASK_GUARD)
                             : guard_cfg;
  wire [7:0]   next_rise   = (wr_ok & sel_rise)
                             ? merge_byte(8'h00, wbyte, DVC_MASK_RISE)
                             : rise_cfg;
  wire [7:0]   next_stage  = (wr_ok & sel_stage)
                             ? merge_byte(8'h00, wbyte, DVC_MASK_STAGE)
                             : stage_cfg;
  wire [1:0]   drain_code  = next_step[DVC_DRAIN_HI:DVC_DRAIN_LO];
  wire [1:0]   next_drain  = (drain_code == DVC_DRAIN_50MA) ? DVC_DRAIN_50MA :
                             (drain_code == DVC_DRAIN_25MA) ? DVC_DRAIN_25MA :
                             DVC_DRAIN_75MA;
  wire         next_stg_en = next_stage[DVC_BIT_STAGE_EN];
  wire         next_drn_off = next_step[DVC_BIT_DRAIN_EN]
                              & ~next_stg_en;

  // ==========================================================================
  // bus handshake: one wait cycle, answer in DVC_ANSWER
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= DVC_IDLE;
    end else begin
      case (state)
        DVC_IDLE:   state <= req ? DVC_ANSWER : DVC_IDLE;
        DVC_ANSWER: state <= DVC_IDLE;
        default:    state <= DVC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      avs_response_o    <= 2'h0;
    end else begin
      avs_waitrequest_o <= ~(req & (state == DVC_IDLE));
      avs_readdata_o    <= {24'h00_0000, rd_byte};
      avs_response_o    <= hit ? 2'h0 : 2'h3;
    end
  end

  // ==========================================================================
  // registers, updated whole on the accepting edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_cfg  <= DVC_RST_STEP;
      guard_cfg <= DVC_RST_GUARD;
      rise_cfg  <= DVC_RST_RISE;
      stage_cfg <= DVC_RST_STAGE;
    end else begin
      step_cfg  <= next_step;
      guard_cfg <= next_guard;
      rise_cfg  <= next_rise;
      stage_cfg <= next_stage;
    end
  end

  // ==========================================================================
  // analog controls, registered from the next values so they track writes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_down_ramp_enable_o     <= DVC_RST_STEP[DVC_BIT_DOWN_RAMP];
      voltage_step_slew_select_o    <= DVC_SLEW_40MV;
      drain_current_select_o        <= DVC_DRAIN_25MA;
      drain_with_stage_enable_o     <= 1'b0;
      drain_to_stop_level_o         <= 1'b0;
      power_stage_enable_o          <= 1'b0;
      drain_on_stage_off_o          <= 1'b0;
      input_overvolt_guard_enable_o <= 1'b0;
      input_regulation_select_o     <= 1'b0;
      supply_detector_enable_o      <= DVC_RST_GUARD[DVC_BIT_DET_EN];
      supply_detector_fall_level_o  <= DVC_RST_GUARD[DVC_LEVEL_HI:DVC_LEVEL_LO];
      supply_detector_rise_level_o  <= DVC_RST_RISE[DVC_LEVEL_HI:DVC_LEVEL_LO];
      fall_level_mv_o               <= DVC_FALL_BASE_MV;
      rise_level_mv_o               <= 14'h0D48;
    end else begin
      active_down_ramp_enable_o     <= next_step[DVC_BIT_DOWN_RAMP];
      voltage_step_slew_select_o    <=
        next_step[DVC_SLEW_HI:DVC_SLEW_LO];
      drain_current_select_o        <= next_drain;
      drain_with_stage_enable_o     <= next_step[DVC_BIT_DRAIN_EN];
      drain_to_stop_level_o         <= next_step[DVC_BIT_DRAIN_STOP];
      power_stage_enable_o          <= next_stg_en;
      drain_on_stage_off_o          <= next_drn_off;
      input_overvolt_guard_enable_o <= next_guard[DVC_BIT_GUARD_EN];
      input_regulation_select_o     <= next_guard[DVC_BIT_REG_SEL];
      supply_detector_enable_o      <= next_guard[DVC_BIT_DET_EN];
      supply_detector_fall_level_o  <=
        next_guard[DVC_LEVEL_HI:DVC_LEVEL_LO];
      supply_detector_rise_level_o  <=
        next_rise[DVC_LEVEL_HI:DVC_LEVEL_LO];
      fall_level_mv_o <= level_mv(DVC_FALL_BASE_MV,
                                  next_guard[DVC_LEVEL_HI:DVC_LEVEL_LO]);
      rise_level_mv_o <= level_mv(DVC_RISE_BASE_MV,
                                  next_rise[DVC_LEVEL_HI:DVC_LEVEL_LO]);
    end
  end

endmodule : dvc_config_regs

`default_nettype wire

//--- tb/dvc_cfg_props_properties.sv
// Purpose: port-level properties of the config bank
// Assumes: one clock, async active-high reset
// Notes:   attached by bind
`timescale 1ns/1ps
`default_nettype none
module dvc_cfg_props import dvc_pkg::*; (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire logic [DVC_ADDR_W-1:0] avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [31:0]           avs_writedata_i,
  input wire logic [3:0]            avs_byteenable_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire logic                  active_down_ramp_enable_o,
  input wire logic [1:0]            voltage_step_slew_select_o,
  input wire logic [1:0]            drain_current_select_o,
  input wire logic                  drain_with_stage_enable_o,
  input wire logic                  drain_to_stop_level_o,
  input wire logic                  power_stage_enable_o,
  input wire logic                  drain_on_stage_off_o,
  input wire logic                  input_overvolt_guard_enable_o,
  input wire logic                  input_regulation_select_o,
  input wire logic                  supply_detector_enable_o,
  input wire logic [4:0]            supply_detector_fall_level_o,
  input wire logic [4:0]            supply_detector_rise_level_o,
  input wire logic [13:0]           fall_level_mv_o,
  input wire logic [13:0]           rise_level_mv_o
);
  // ==========================================================================
  // helpers
  wire rd_ok = avs_read_i & ~avs_waitrequest_o;
  wire at_step = avs_address_i == DVC_ADDR_STEP;
  wire at_guard = avs_address_i == DVC_ADDR_GUARD;
  wire at_rise = avs_address_i == DVC_ADDR_RISE;
  wire at_stage = avs_address_i == DVC_ADDR_STAGE;
  wire [1:0] code = avs_readdata_o[3:2];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // properties
  step_unimpl_zero_a: assert property (
    rd_ok && at_step |-> !avs_readdata_o[7]) else $error("step bit 7 set");
  rise_unimpl_zero_a: assert property (
    rd_ok && at_rise |-> avs_readdata_o[7:5] == 3'h0)
    else $error("rise bits 7:5 set");
  step_read_match_a: assert property (
    rd_ok && at_step |-> avs_readdata_o[6:4] ==
    {active_down_ramp_enable_o, voltage_step_slew_select_o})
    else $error("step fields differ from readback");
  drain_code_fold_a: assert property (
    rd_ok && at_step |->
    drain_current_select_o == (code == 2'h3 ? 2'h2 : code))
    else $error("drain select wrong");
  drain_bits_match_a: assert property (
    rd_ok && at_step |-> avs_readdata_o[1:0] ==
    {drain_with_stage_enable_o, drain_to_stop_level_o})
    else $error("drain option bits differ");
  drain_stage_tie_a: assert property (
    drain_on_stage_off_o ==
    (drain_with_stage_enable_o & ~power_stage_enable_o))
    else $error("drain tie wrong");
  guard_read_match_a: assert property (
    rd_ok && at_guard |-> avs_readdata_o[7:0] ==
    {input_overvolt_guard_enable_o, input_regulation_select_o,
    supply_detector_enable_o, supply_detector_fall_level_o})
    else $error("guard fields differ");
  fall_mv_map_a: assert property (
    fall_level_mv_o == DVC_FALL_BASE_MV +
    DVC_LEVEL_STEP_MV * {9'h0, supply_detector_fall_level_o})
    else $error("fall level mv wrong");
  rise_mv_map_a: assert property (
    rise_level_mv_o == DVC_RISE_BASE_MV +
    DVC_LEVEL_STEP_MV * {9'h0, supply_detector_rise_level_o})
    else $error("rise level mv wrong");
  rise_read_match_a: assert property (
    rd_ok && at_rise |-> avs_readdata_o[4:0] == supply_detector_rise_level_o)
    else $error("rise field differs");
  stage_read_match_a: assert property (
    rd_ok && at_stage |-> avs_readdata_o[0] == power_stage_enable_o)
    else $error("stage enable differs");
  step_write_now_a: assert property (
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && at_step |=>
    {active_down_ramp_enable_o, voltage_step_slew_select_o} ==
    $past(avs_writedata_i[6:4])) else $error("step write late");
endmodule : dvc_cfg_props
bind dvc_config_regs dvc_cfg_props u_props (.*);
`default_nettype wire

//--- tb/dvc_host_model.sv
// Purpose: Avalon-MM host issuing single register accesses
// Assumes: slave answers via waitrequest
// Notes:   waits without limit; the bench watchdog ends hangs
`timescale 1ns/1ps
`default_nettype none
module dvc_host_model (
  input  wire logic        clk_i,
  input  wire logic        wait_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  resp_i,
  output logic      [9:0]  adr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wd_o,
  output logic      [3:0]  be_o
);
  initial begin
    {adr_o, rd_o, wr_o, wd_o, be_o} = '0;
  end
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] b,
                     output logic [7:0] q, output logic [1:0] r);
    @(posedge clk_i);
    {rd_o, wr_o} <= {~w, w};
    adr_o <= a;
    wd_o <= {24'h0, d};
    be_o <= b;
    do @(posedge clk_i); while (wait_i !== 1'b0);
    q = rdata_i[7:0];
    r = resp_i;
    {rd_o, wr_o} <= 2'b00;
  endtask : acc
endmodule : dvc_host_model
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the config bank
// Assumes: 125 MHz clock, reset high 10 cycles
// Notes:   table rows write then read back
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dvc_pkg::*;
  typedef struct packed {
    logic [9:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;
  } dvc_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] avs_address_i;
  logic avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic active_down_ramp_enable_o, drain_with_stage_enable_o;
  logic drain_to_stop_level_o, power_stage_enable_o, drain_on_stage_off_o;
  logic input_overvolt_guard_enable_o, input_regulation_select_o;
  logic supply_detector_enable_o;
  logic [1:0] avs_response_o, voltage_step_slew_select_o;
  logic [1:0] drain_current_select_o;
  logic [4:0] supply_detector_fall_level_o, supply_detector_rise_level_o;
  logic [13:0] fall_level_mv_o, rise_level_mv_o;
  int errors = 0;
  int tests_run = 0;
  logic [7:0] q;
  logic [1:0] r;
  dvc_row_t rows [10] = '{
    '{DVC_ADDR_STEP, 8'hFF, 8'h7F, 2'h0}, '{DVC_ADDR_STEP, 8'h1C, 8'h1C, 2'h0},
    '{DVC_ADDR_STEP, 8'h2B, 8'h2B, 2'h0}, '{DVC_ADDR_STEP, 8'hB4, 8'h34, 2'h0},
    '{DVC_ADDR_GUARD, 8'hFF, 8'hFF, 2'h0},
    '{DVC_ADDR_GUARD, 8'h40, 8'h40, 2'h0},
    '{DVC_ADDR_RISE, 8'hFF, 8'h1F, 2'h0}, '{DVC_ADDR_RISE, 8'h0A, 8'h0A, 2'h0},
    '{DVC_ADDR_STAGE, 8'hFF, 8'h01, 2'h0}, '{10'h3FC, 8'hAA, 8'h00, 2'h3}};
  always #4 sys_clk_i = ~sys_clk_i;
  dvc_config_regs DUT (.*);
  dvc_host_model host (.clk_i(sys_clk_i), .wait_i(avs_waitrequest_o),
    .rdata_i(avs_readdata_o), .resp_i(avs_response_o), .adr_o(avs_address_i),
    .rd_o(avs_read_i), .wr_o(avs_write_i), .wd_o(avs_writedata_i),
    .be_o(avs_byteenable_i));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [9:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    host.acc(1'b0, a, 8'h00, 4'h1, q, r);
    chk({q, 6'h0, r}, {e, 6'h0, er});
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, 4'h1, q, r);
    // outputs launched at the accepting edge settle by the next one
    @(posedge sys_clk_i);
  endtask : wr
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #40000;
    errors++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(DVC_ADDR_STEP, 8'h40, 2'h0);
    rd(DVC_ADDR_GUARD, 8'h20, 2'h0);
    rd(DVC_ADDR_RISE, 8'h03, 2'h0);
    rd(DVC_ADDR_STAGE, 8'h00, 2'h0);
    chk({2'h0, fall_level_mv_o}, 16'h0A8C);
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("test table done");
    wr(DVC_ADDR_STAGE, 8'h00);
    wr(DVC_ADDR_STEP, 8'h0E);
    chk({15'h0, drain_on_stage_off_o}, 16'h0001);
    chk({14'h0, drain_current_select_o}, 16'h0002);
    wr(DVC_ADDR_STAGE, 8'h01);
    chk({15'h0, drain_on_stage_off_o}, 16'h0000);
    wr(DVC_ADDR_GUARD, 8'h1F);
    wr(DVC_ADDR_RISE, 8'h1F);
    chk({2'h0, fall_level_mv_o}, 16'h22C4);
    chk({2'h0, rise_level_mv_o}, 16'h2328);
    $display("test drain and levels done");
    // a write with its byte lane off is answered but changes nothing
    host.acc(1'b1, DVC_ADDR_GUARD, 8'hE0, 4'h0, q, r);
    rd(DVC_ADDR_GUARD, 8'h1F, 2'h0);
    chk({15'h0, input_overvolt_guard_enable_o}, 16'h0000);
    $display("test disabled lane done");
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(DVC_ADDR_STEP, 8'h40, 2'h0);
    chk({2'h0, rise_level_mv_o}, 16'h0D48);
    $display("test second reset done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
